// File: src/plc_phaselock_ctrl.sv
// Purpose: Phaselock control board logic behind an APB register port
// Assumes: Inputs are synchronised here; reference arrives as a tick input
// Notes:   Talk reads walk three bytes; listen writes drive the serial lines
`timescale 1ns/10ps
`default_nettype none
//
// Behaviour
// R01: Read only at talk, write only listen
// R02: Limit rise fires 35 us shot, sets request
// R03: Poll with address bit seven pulls D2 low
// R04: Address bit seven low, D2 low cancels
// R05: Limit levels readable in first byte
// R06: Listen write passes byte to outputs
// R07: D0 is serial divider data bit
// R08: D1 drives divider latch; D2 unused
// R09: D3 resets readback sequencer
// R10: D4 strobes error amplifier control word
// R11: D5 clears prescaler and counter
// R12: D6 captured on delayed clock selects source
// R13: D7 is serial clock, delayed after data
// R14: First falling edge starts; eight opens gate
// R15: Sixteenth edge closes gate, sets complete
// R16: Gate open counts reference, 20 bits
// R17: Count held until clear
// R18: Talk reads three bytes, each release advances
// R19: Controller polls complete bit before reading
// R20: Search pulses keep lock low until timeout
// R21: Lock shot active masks limit inputs
// R22: Timeouts counted in clocks; inputs synchronised
// R23: Limit inputs mean coil drive nears range
module plc_phaselock_ctrl
    import plc_pkg::*;
#(
    parameter int unsigned LOCK_HOLD_CYCLES = LOCK_HOLD_DEFAULT
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire logic              limit_up,
    input  wire logic              limit_down,
    input  wire logic              search,
    input  wire logic              f_error,
    input  wire logic              alt_source,
    input  wire logic              ref_tick,
    input  wire logic              poll_strobe,
    input  wire logic              address_bit_seven,
    input  wire logic              d2_in,
    output var  logic              d2_out,
    output var  logic              d2_oe,
    output var  logic              srq,
    output var  logic              ser_data,
    output var  logic              ser_clk,
    output var  logic              n_latch,
    output var  logic              ctl_latch,
    output var  logic              src_sel,
    output var  logic              lock,
    output var  logic              count_valid
);

    plc_state_type        s_reg;
    plc_state_type        s_next;
    plc_pins_type         pins_raw;
    plc_pins_type         pins;
    logic [COUNT_W-1:0]   count_inc;
    logic [STAGES:0]      carry;
    logic                 setup;
    logic                 done;
    logic                 talk_sel;
    logic                 listen_sel;
    logic                 clr;
    logic                 gate_open_tap;
    logic                 gate_close_tap;
    logic                 meas;
    logic                 lim_m;
    logic                 trig;
    logic                 cancel;
    logic                 fire;
    logic                 talk_rd;
    logic                 listen_wr;
    logic [7:0]           rb;

    function automatic logic addr_match(input logic [ADDR_W-1:0] a,
                                        input logic [ADDR_W-1:0] b);
        addr_match = (a == b);
    endfunction

    assign pins_raw = '{limit_up: limit_up, limit_down: limit_down, search: search,
                        f_error: f_error, alt_source: alt_source, ref_tick: ref_tick,
                        poll_strobe: poll_strobe, address_bit_seven: address_bit_seven,
                        d2_in: d2_in};

    plc_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pins_raw),
        .sync_out (pins)
    );

    // Five four-bit counter stages with ripple carry
    assign carry[0] = 1'b1;
    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_stage
            assign count_inc[g*STAGE_W +: STAGE_W] = carry[g] ?
                s_reg.count[g*STAGE_W +: STAGE_W] + 4'h1 :
                s_reg.count[g*STAGE_W +: STAGE_W];  // R16
            assign carry[g+1] = carry[g] & (&s_reg.count[g*STAGE_W +: STAGE_W]);
        end
    endgenerate

    assign setup          = psel & ~penable & ~s_reg.pready;
    assign done           = psel & penable & s_reg.pready;
    assign talk_sel       = addr_match(paddr, TALK_ADDR);  // R01
    assign listen_sel     = addr_match(paddr, LISTEN_ADDR);  // R01
    assign clr            = s_reg.out_byte[CLEAR_BIT];  // R11
    assign gate_open_tap  = s_reg.presc[OPEN_TAP];
    assign gate_close_tap = s_reg.presc[CLOSE_TAP];
    assign meas           = s_reg.src_sel ? pins.f_error : pins.alt_source;
    assign lim_m          = (pins.limit_up | pins.limit_down) & s_reg.lock;  // R21 R23
    assign trig           = lim_m & ~s_reg.lim_q;
    assign cancel         = s_reg.srq_latch & s_reg.ab7_q & ~pins.address_bit_seven
                            & ~pins.d2_in;  // R04
    assign fire           = trig & (s_reg.os_cnt == '0);  // R02
    assign talk_rd        = done & ~pwrite & talk_sel;  // R18
    assign listen_wr      = done & pwrite & listen_sel;  // R06

    // Readback byte for the current sequencer step
    always_comb begin
        rb = 8'h00;
        case (s_reg.seq)
            SEQ_STATUS: begin
                rb[RB_UPPER_BIT] = pins.limit_up;  // R05
                rb[RB_LOWER_BIT] = pins.limit_down;  // R05
                rb[RB_LOCK_BIT]  = s_reg.lock;  // R20
                rb[RB_VALID_BIT] = gate_close_tap;  // R15 R18
                rb[3:2]          = s_reg.count[17:16];
                rb[6:5]          = s_reg.count[19:18];
            end
            SEQ_MID: begin
                rb = s_reg.count[15:8];
            end
            SEQ_LOW: begin
                rb = s_reg.count[7:0];
            end
            default: begin
                rb = 8'h00;
            end
        endcase
    end

    always_comb begin
        s_next = s_reg;
        // APB: one wait-free access phase, answer registered in setup
        if (setup) begin
            s_next.pready = 1'b1;
            s_next.prdata = (!pwrite && talk_sel) ? {RB_PAD, rb} : DATA_ZERO;  // R01
        end else if (done) begin
            s_next.pready = 1'b0;
            s_next.prdata = DATA_ZERO;
        end
        if (listen_wr) begin
            s_next.out_byte = pwdata[7:0];  // R06 R07 R08 R10
        end
        s_next.ser_clk = s_reg.out_byte[SER_CLK_BIT];  // R13
        if (s_reg.out_byte[SER_CLK_BIT] && !s_reg.ser_clk) begin
            s_next.src_sel = s_reg.out_byte[SRC_SEL_BIT];  // R12
        end
        // Readback sequencer
        if (s_reg.out_byte[SEQ_RESET_BIT]) begin
            s_next.seq = SEQ_STATUS;  // R09
        end else if (talk_rd) begin
            case (s_reg.seq)
                SEQ_STATUS: s_next.seq = SEQ_MID;  // R18
                SEQ_MID:    s_next.seq = SEQ_LOW;
                SEQ_LOW:    s_next.seq = SEQ_STATUS;
                default:    s_next.seq = SEQ_STATUS;
            endcase
        end
        // Prescaler and reference counter
        s_next.meas_q = meas;
        s_next.ref_q  = pins.ref_tick;
        if (clr) begin
            s_next.presc = '0;  // R11
            s_next.count = '0;
        end else begin
            if (s_reg.meas_q && !meas && !gate_close_tap) begin
                s_next.presc = s_reg.presc + 5'h01;  // R14 R15
            end
            if (gate_open_tap && !gate_close_tap && pins.ref_tick && !s_reg.ref_q) begin
                s_next.count = count_inc;  // R16 R17
            end
        end
        // Lock sensor, retriggerable
        s_next.search_q = pins.search;
        if (pins.search && !s_reg.search_q) begin
            s_next.lock_cnt = LOCK_W'(LOCK_HOLD_CYCLES);  // R20 R22
        end else if (s_reg.lock_cnt != '0) begin
            s_next.lock_cnt = s_reg.lock_cnt - 12'h001;
        end
        s_next.lock = (s_next.lock_cnt == '0);  // R20
        // Service request
        s_next.lim_q = lim_m;
        s_next.ab7_q = pins.address_bit_seven;
        if (fire) begin
            s_next.os_cnt = OS_W'(SRQ_PULSE_CYCLES);  // R02 R22
        end else if (s_reg.os_cnt != '0) begin
            s_next.os_cnt = s_reg.os_cnt - 10'h001;
        end
        // A trigger inside a running shot does not set the latch again
        if (fire) begin
            s_next.srq_latch = 1'b1;  // R02
        end else if (cancel) begin
            s_next.srq_latch = 1'b0;  // R04
        end
        s_next.d2_oe = s_next.srq_latch & pins.poll_strobe & pins.address_bit_seven;  // R03
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg          <= '0;
            s_reg.seq      <= SEQ_STATUS;
            s_reg.lock     <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
            d2_out  <= 1'b0;
        end else begin
            pslverr <= 1'b0;
            d2_out  <= 1'b0;
        end
    end

    // Outputs straight from state flops
    assign prdata      = s_reg.prdata;
    assign pready      = s_reg.pready;
    assign d2_oe       = s_reg.d2_oe;
    assign srq         = s_reg.srq_latch;
    assign ser_data    = s_reg.out_byte[SER_DATA_BIT];
    assign ser_clk     = s_reg.ser_clk;
    assign n_latch     = s_reg.out_byte[N_LATCH_BIT];
    assign ctl_latch   = s_reg.out_byte[CTL_LATCH_BIT];
    assign src_sel     = s_reg.src_sel;
    assign lock        = s_reg.lock;
    assign count_valid = s_reg.presc[CLOSE_TAP];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    talk_decode_a: assert property (setup && !(talk_sel && !pwrite) |=> prdata == DATA_ZERO) // R01
        else $error("Non-talk access returned data");
    listen_decode_a: assert property (done && pwrite && !listen_sel |=> $stable(s_reg.out_byte)) // R01
        else $error("Write outside listen address took effect");
    srq_fire_a: assert property (trig && s_reg.os_cnt == '0 |=> srq && s_reg.os_cnt == OS_W'(SRQ_PULSE_CYCLES)) // R02
        else $error("Limit rise did not fire request");
    poll_answer_a: assert property (srq && pins.poll_strobe && pins.address_bit_seven && !trig |=> d2_oe) // R03
        else $error("Poll not answered on D2");
    cancel_clear_a: assert property (cancel && !fire |=> !srq && !d2_oe) // R04
        else $error("Request not cancelled");
    status_read_a: assert property (setup && !pwrite && talk_sel && s_reg.seq == SEQ_STATUS
                                    |=> prdata[RB_UPPER_BIT] == $past(pins.limit_up)) // R05
        else $error("Upper limit not in first byte");
    clk_delay_a: assert property ($rose(s_reg.out_byte[SER_CLK_BIT]) |-> !ser_clk ##1 ser_clk) // R13
        else $error("Serial clock not delayed");
    count_hold_a: assert property (gate_close_tap && !clr |=> $stable(s_reg.count)) // R17
        else $error("Count moved after gate closed");
    clear_all_a: assert property (clr |=> s_reg.presc == '0 && s_reg.count == '0) // R11
        else $error("Clear did not empty counters");
    seq_wrap_a: assert property (done && !pwrite && talk_sel && !s_reg.out_byte[SEQ_RESET_BIT]
                                 && s_reg.seq == SEQ_LOW |=> s_reg.seq == SEQ_STATUS) // R18
        else $error("Sequencer did not wrap");
    lock_drop_a: assert property ($rose(pins.search) |=> !lock) // R20
        else $error("Search pulse did not drop lock");
    limit_mask_a: assert property (!lock && !srq |=> !srq) // R21
        else $error("Request raised while searching");

    shot_block_a: assert property (trig && s_reg.os_cnt != '0 // R02
                                   && !s_reg.srq_latch |=> !srq)
        else $error("Request raised during one-shot");
    shot_count_a: assert property (s_reg.os_cnt != '0 // R22
                                   |=> s_reg.os_cnt == $past(s_reg.os_cnt) - 10'h001)
        else $error("One-shot did not count down");
    poll_quiet_a: assert property (!srq && !fire |=> !d2_oe) // R03
        else $error("D2 pulled without a request");
    cancel_needs_a: assert property (srq && pins.d2_in |=> srq) // R04
        else $error("Request cancelled with D2 high");
    write_pass_a: assert property (listen_wr |=> s_reg.out_byte == $past(pwdata[7:0])) // R06
        else $error("Listen byte not taken");
    ser_data_a: assert property (listen_wr |=> ser_data == $past(pwdata[SER_DATA_BIT])) // R07
        else $error("Serial data bit wrong");
    n_latch_a: assert property (listen_wr |=> n_latch == $past(pwdata[N_LATCH_BIT])) // R08
        else $error("Divider latch bit wrong");
    ctl_latch_a: assert property (listen_wr |=> ctl_latch == $past(pwdata[CTL_LATCH_BIT])) // R10
        else $error("Control latch bit wrong");
    seq_reset_a: assert property (s_reg.out_byte[SEQ_RESET_BIT] // R09
                                  |=> s_reg.seq == SEQ_STATUS)
        else $error("Sequencer not held at first byte");
    src_capture_a: assert property ($rose(ser_clk) // R12
                                    |-> src_sel == $past(s_reg.out_byte[SRC_SEL_BIT]))
        else $error("Source select not captured");
    ser_clk_follow_a: assert property (ser_clk == $past(s_reg.out_byte[SER_CLK_BIT])) // R13
        else $error("Serial clock not one cycle behind");

    gate_idle_a: assert property (!gate_open_tap && !clr |=> $stable(s_reg.count)) // R14
        else $error("Count moved with gate shut");
    presc_stop_a: assert property (gate_close_tap && !clr |=> $stable(s_reg.presc)) // R15
        else $error("Prescaler ran after sixteen");
    gate_count_a: assert property (gate_open_tap && !gate_close_tap && !clr // R16
                                   && pins.ref_tick && !s_reg.ref_q
                                   |=> s_reg.count == $past(s_reg.count) + 20'h0_0001)
        else $error("Reference edge not counted");
    seq_step_a: assert property (talk_rd && !s_reg.out_byte[SEQ_RESET_BIT] // R18
                                 && s_reg.seq == SEQ_STATUS |=> s_reg.seq == SEQ_MID)
        else $error("Sequencer did not advance");
    valid_bit_a: assert property (setup && !pwrite && talk_sel && s_reg.seq == SEQ_STATUS // R15
                                  |=> prdata[RB_VALID_BIT] == $past(gate_close_tap))
        else $error("Complete bit not in first byte");
    lock_bit_a: assert property (setup && !pwrite && talk_sel && s_reg.seq == SEQ_STATUS // R20
                                 |=> prdata[RB_LOCK_BIT] == $past(lock))
        else $error("Lock bit not in first byte");
    lock_timeout_a: assert property (s_reg.lock_cnt == 12'h001 // R20
                                     && !(pins.search && !s_reg.search_q) |=> lock)
        else $error("Lock did not return after timeout");
    pready_one_a: assert property (pready |=> !pready) // R01
        else $error("Ready stood longer than one cycle");
    prdata_idle_a: assert property (!pready |-> prdata == DATA_ZERO) // R18
        else $error("Read data left on idle bus");

    srq_cycle_c: cover property (trig ##[1:50] cancel);
    count_done_c: cover property ($rose(gate_close_tap));
    lock_gain_c: cover property ($rose(lock));
    three_read_c: cover property (s_reg.seq == SEQ_LOW ##1 s_reg.seq == SEQ_STATUS);
    poll_cancel_c: cover property (d2_oe ##[1:20] !srq);

endmodule
`default_nettype wire

// File: src/plc_pkg.sv
// Purpose: Shared constants and types for the phaselock control block
// Assumes: pclk at 20 MHz; registers reached over APB with 32-bit data
// Notes:   Talk and listen addresses are register indexes; byte address is four times
package plc_pkg;

    localparam int unsigned CLK_PERIOD_NS     = 50;
    localparam int unsigned SRQ_PULSE_NS      = 35000;
    localparam int unsigned SRQ_PULSE_CYCLES  = (SRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOCK_HOLD_DEFAULT = 2000;

    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned TALK_INDEX  = 8'hF3;
    localparam int unsigned LISTEN_INDEX = 8'h73;
    localparam logic [ADDR_W-1:0] TALK_ADDR   = ADDR_W'(TALK_INDEX * 4);
    localparam logic [ADDR_W-1:0] LISTEN_ADDR = ADDR_W'(LISTEN_INDEX * 4);

    // Written byte fields
    localparam int unsigned SER_DATA_BIT  = 0;
    localparam int unsigned N_LATCH_BIT   = 1;
    localparam int unsigned SEQ_RESET_BIT = 3;
    localparam int unsigned CTL_LATCH_BIT = 4;
    localparam int unsigned CLEAR_BIT     = 5;
    localparam int unsigned SRC_SEL_BIT   = 6;
    localparam int unsigned SER_CLK_BIT   = 7;

    // First readback byte fields
    localparam int unsigned RB_UPPER_BIT = 0;
    localparam int unsigned RB_LOWER_BIT = 1;
    localparam int unsigned RB_LOCK_BIT  = 4;
    localparam int unsigned RB_VALID_BIT = 7;

    localparam int unsigned STAGE_W   = 4;
    localparam int unsigned STAGES    = 5;
    localparam int unsigned COUNT_W   = STAGE_W * STAGES;
    localparam int unsigned PRESC_W   = 5;
    localparam int unsigned OPEN_TAP  = 3;
    localparam int unsigned CLOSE_TAP = 4;
    localparam int unsigned OS_W      = 10;
    localparam int unsigned LOCK_W    = 12;
    localparam int unsigned PIN_COUNT = 9;

    localparam logic [23:0] RB_PAD    = 24'h00_0000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        SEQ_STATUS = 3'b001,
        SEQ_MID    = 3'b010,
        SEQ_LOW    = 3'b100
    } plc_seq_type;

    typedef struct packed {
        logic limit_up;
        logic limit_down;
        logic search;
        logic f_error;
        logic alt_source;
        logic ref_tick;
        logic poll_strobe;
        logic address_bit_seven;
        logic d2_in;
    } plc_pins_type;

    typedef struct packed {
        logic                 pready;
        logic [31:0]          prdata;
        logic [7:0]           out_byte;
        logic                 ser_clk;
        logic                 src_sel;
        plc_seq_type          seq;
        logic [PRESC_W-1:0]   presc;
        logic [COUNT_W-1:0]   count;
        logic [OS_W-1:0]      os_cnt;
        logic                 srq_latch;
        logic                 d2_oe;
        logic [LOCK_W-1:0]    lock_cnt;
        logic                 lock;
        logic                 meas_q;
        logic                 ref_q;
        logic                 lim_q;
        logic                 search_q;
        logic                 ab7_q;
    } plc_state_type;

endpackage

// File: src/plc_sync.sv
// Purpose: Two-stage synchroniser for the asynchronous pin inputs
// Assumes: One clock domain, pclk
// Notes:   Only the second stage leaves this module
`timescale 1ns/10ps
`default_nettype none
module plc_sync
    import plc_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [PIN_COUNT-1:0] async_in,
    output var  logic [PIN_COUNT-1:0] sync_out
);

    logic [PIN_COUNT-1:0] meta_reg;

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_reg[g] <= 1'b0;
                    sync_out[g] <= 1'b0;
                end else begin
                    meta_reg[g] <= async_in[g];  // R22
                    sync_out[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// File: test/plc_pin_model.sv
// Purpose: Pin-side partner: error signal, reference tick, search pulses, D2 wire
// Assumes: Reference tick every 4 pclk; error period is 4*f_k pclk
// Notes:   Error falls two cycles clear of a tick rise; D2 has a pull-up
`timescale 1ns/10ps
`default_nettype none
module plc_pin_model
    import plc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic [3:0] f_k,
    input  wire logic       search_en,
    input  wire logic       d2_oe,
    input  wire logic       host_d2_low,
    output var  logic       f_error,
    output var  logic       ref_tick,
    output var  logic       search,
    output var  logic       d2_in
);
    logic [7:0] f_cnt = 8'h00;
    logic [3:0] s_cnt = 4'h0;
    always_ff @(posedge pclk) begin
        f_cnt <= (f_cnt >= {2'h0, f_k, 2'h0} - 8'h01) ? 8'h00 : f_cnt + 8'h01;
        s_cnt <= (s_cnt == 4'h9) ? 4'h0 : s_cnt + 4'h1;
    end
    assign ref_tick = f_cnt[1];
    assign f_error  = (f_cnt >= {3'h0, f_k, 1'h0});
    assign search   = search_en & (s_cnt < 4'h3);
    assign d2_in    = ~(d2_oe | host_d2_low);
endmodule
`default_nettype wire

// File: test/tb_plc_phaselock_ctrl.sv
// Purpose: Self-checking bench for the phaselock control block
// Assumes: APB master, limit, poll and source pins in this bench; error, tick, search and D2 from plc_pin_model
// Notes:   Lock hold shortened to 20 cycles
`timescale 1ns/10ps
`default_nettype none
module tb_plc_phaselock_ctrl
    import plc_pkg::*;
;
    localparam int unsigned LOCK_T = 20;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, seed;
    logic [31:0]       ex [3];
    logic              limit_up, limit_down, search, f_error, alt_source, ref_tick;
    logic              poll_strobe, address_bit_seven, d2_in, d2_out, d2_oe, srq;
    logic              ser_data, ser_clk, n_latch, ctl_latch, src_sel, lock, count_valid;
    logic              search_en, host_d2_low, exp_src, prev_clk;
    logic [3:0]        f_k;
    logic [7:0]        b;
    logic [19:0]       cnt;
    int                num_errors, total_checks, n;

    plc_phaselock_ctrl #(.LOCK_HOLD_CYCLES(LOCK_T)) i_plc_phaselock_ctrl (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .limit_up, .limit_down, .search, .f_error, .alt_source,
        .ref_tick, .poll_strobe, .address_bit_seven, .d2_in, .d2_out, .d2_oe, .srq,
        .ser_data, .ser_clk, .n_latch, .ctl_latch, .src_sel, .lock, .count_valid
    );
    plc_pin_model i_plc_pin_model (
        .pclk, .f_k, .search_en, .d2_oe, .host_d2_low, .f_error, .ref_tick,
        .search, .d2_in
    );

    always #25 pclk = ~pclk;
    always @(posedge pclk) alt_source <= seed[3];

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], 1'h0} ^ (s[31] ? 32'h0400_0007 : DATA_ZERO);
    endfunction

    function automatic logic [31:0] b0(input logic v, input logic [19:0] c,
                                       input logic lk, input logic lo, input logic up);
        return {RB_PAD, v, c[19:18], lk, c[17:16], lo, up};
    endfunction

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] wd);
        int k;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {RB_PAD, wd};
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 16);
        rd = prdata;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) chk(pready, 1'h1);
    endtask

    task automatic wr(input logic [7:0] v);
        apb(1'h1, LISTEN_ADDR, v);
    endtask

    task automatic rdb;
        apb(1'h0, TALK_ADDR, 8'h00);
    endtask

    task automatic seq(input logic [7:0] base);
        wr(base | 8'h08);
        wr(base);
    endtask

    initial begin
        pclk = 1'h0; presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
        paddr = '0; pwdata = DATA_ZERO; limit_up = 1'h0; limit_down = 1'h0;
        alt_source = 1'h0; poll_strobe = 1'h0; address_bit_seven = 1'h0;
        search_en = 1'h0; host_d2_low = 1'h0; f_k = 4'h8; seed = 32'h880a_34dd;
        num_errors = 0; total_checks = 0;
        cyc(4);
        chk(lock, 1'h1);
        chk({srq, count_valid, d2_oe}, 3'h0);
        cyc(1);
        presetn <= 1'h1;
        cyc(3);
        apb(1'h0, LISTEN_ADDR, 8'h00);
        chk(rd, DATA_ZERO);
        apb(1'h0, {seed[11:2], 2'h0} | 12'h800, 8'h00);
        chk(rd, DATA_ZERO);
        apb(1'h1, TALK_ADDR, 8'h13);
        cyc(3);
        chk({ser_data, n_latch, pslverr}, 3'h0);
        exp_src = 1'h0;
        prev_clk = 1'h0;
        for (int i = 0; i < 12; i++) begin
            seed = nxt(seed);
            b = (i < 3) ? (i[1] ? 8'h3F : {i[0], 7'h40}) : seed[7:0];
            wr(b);
            cyc(1);
            chk(ser_clk, prev_clk);
            chk(ser_data, b[0]);
            if (b[7] && !prev_clk) exp_src = b[6];
            prev_clk = b[7];
            cyc(2);
            chk({n_latch, ctl_latch, ser_clk}, {b[1], b[4], b[7]});
            chk(src_sel, exp_src);
        end
        seed = nxt(seed);
        f_k <= {1'h1, seed[2:0]};
        wr(8'h40);
        wr(8'hC0);
        wr(8'hE0);
        wr(8'hC0);
        n = 0;
        do begin
            seq(8'hC0);
            rdb();
            n++;
        end while (rd[7] !== 1'h1 && n < 200);
        cnt = 20'({f_k, 3'h0});
        ex[0] = b0(1'h1, cnt, 1'h1, 1'h0, 1'h0);
        ex[1] = {RB_PAD, cnt[15:8]};
        ex[2] = {RB_PAD, cnt[7:0]};
        chk(rd, ex[0]);
        chk(count_valid, 1'h1);
        for (int i = 1; i < 6; i++) begin
            if (i == 3) cyc(300);
            rdb();
            chk(rd, ex[i % 3]);
        end
        wr(8'hE0);
        cyc(3);
        chk(count_valid, 1'h0);
        seq(8'hE0);
        rdb();
        chk(rd, b0(1'h0, 20'h0_0000, 1'h1, 1'h0, 1'h0));
        search_en <= 1'h1;
        cyc(10);
        chk(lock, 1'h0);
        limit_up <= 1'h1;
        cyc(10);
        chk(srq, 1'h0);
        seq(8'hE0);
        rdb();
        chk({rd[4], rd[1:0]}, 3'h1);
        limit_up <= 1'h0;
        search_en <= 1'h0;
        cyc(8);
        chk(lock, 1'h0);
        cyc(20);
        chk(lock, 1'h1);
        poll_strobe <= 1'h1;
        address_bit_seven <= 1'h1;
        cyc(5);
        chk(d2_oe, 1'h0);
        limit_up <= 1'h1;
        cyc(6);
        chk(srq, 1'h1);
        chk({d2_oe, d2_in, d2_out}, 3'h4);
        poll_strobe <= 1'h0;
        host_d2_low <= 1'h1;
        address_bit_seven <= 1'h0;
        cyc(5);
        chk({srq, d2_oe}, 2'h0);
        host_d2_low <= 1'h0;
        limit_up <= 1'h0;
        cyc(4);
        limit_down <= 1'h1;
        cyc(6);
        chk(srq, 1'h0);
        limit_down <= 1'h0;
        cyc(SRQ_PULSE_CYCLES);
        limit_down <= 1'h1;
        cyc(6);
        chk(srq, 1'h1);
        address_bit_seven <= 1'h1;
        cyc(4);
        address_bit_seven <= 1'h0;
        cyc(5);
        chk(srq, 1'h1);
        end_sim();
    end

    initial begin
        cyc(20000);
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
